// file: common/nmd_pkg.sv
package nmd_pkg;

    // Register byte offsets (low address byte)
    localparam logic [7:0] OFS_INSTR   = 8'h00;
    localparam logic [7:0] OFS_DEST    = 8'h04;
    localparam logic [7:0] OFS_OPERAND = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_PEND    = 8'h10;
    localparam logic [7:0] OFS_TIMING  = 8'h14;

    // Field positions
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_CS_LSB    = 1;
    localparam int ST_BAD_BIT   = 5;
    localparam int PI_OVF_BIT   = 4;
    localparam int TM_CLK_LSB   = 0;
    localparam int TM_FETCH_LSB = 8;
    localparam int TM_OPND_LSB  = 16;

    // Opcodes
    localparam logic [7:0] OPC_DSUB_MEM = 8'hb6;
    localparam logic [7:0] OPC_DSUB_REG = 8'hb7;
    localparam logic [7:0] OPC_NEG      = 8'hb4;
    localparam logic [7:0] OPC_TWOS_COMPLEMENT_DOUBLE     = 8'hb5;
    localparam logic [7:0] OPC_DMUL_MEM = 8'hc6;
    localparam logic [7:0] OPC_DMUL_REG = 8'hc7;
    localparam logic [7:0] OPC_DIV_MEM  = 8'hd0;
    localparam logic [7:0] OPC_DIV_REG  = 8'hd1;
    localparam logic [7:0] OPC_DIV_POS  = 8'hd2;
    localparam logic [7:0] OPC_DIV_NEG  = 8'hd3;
    localparam logic [7:0] OPC_IMM_GRP  = 8'h4a;
    localparam logic [3:0] SUB_DIV_IMM  = 4'h6;

    // Condition status codes
    localparam logic [3:0] CS_ZERO  = 4'h2;
    localparam logic [3:0] CS_NEG   = 4'h1;
    localparam logic [3:0] CS_POS   = 4'h4;
    localparam logic [3:0] CS_CARRY = 4'h8;
    localparam logic [3:0] CS_RESET = 4'h0;

    // Special values
    localparam logic [15:0] MOST_NEG_16 = 16'h8000;
    localparam logic [15:0] ALL_ONES_16 = 16'hffff;
    localparam logic [31:0] MOST_NEG_32 = 32'h8000_0000;
    localparam logic [31:0] ALL_ONES_32 = 32'hffff_ffff;
    localparam logic [15:0] ONE_16      = 16'h0001;

    // Clock counts
    localparam logic [7:0] CLK_DSUB_MEM = 8'h18;
    localparam logic [7:0] CLK_DSUB_REG = 8'h12;
    localparam logic [7:0] CLK_NEG      = 8'h05;
    localparam logic [7:0] CLK_TWOS_COMPLEMENT_DOUBLE     = 8'h12;
    localparam logic [7:0] CLK_DMUL_MEM = 8'h84;
    localparam logic [7:0] CLK_DMUL_REG = 8'h7e;
    localparam logic [7:0] CLK_DIV_SHRT = 8'h62;
    localparam logic [7:0] CLK_DIV_REG  = 8'h62;
    localparam logic [7:0] CLK_DIV_IMM  = 8'h66;
    localparam logic [7:0] CLK_DIV_MEM  = 8'h67;
    localparam logic [7:0] CNT_LAST     = 8'h01;

    // Bus cycle counts
    localparam logic [1:0] BUS_NONE = 2'h0;
    localparam logic [1:0] BUS_ONE  = 2'h1;
    localparam logic [1:0] BUS_TWO  = 2'h2;

    localparam logic [4:0] DIV_STEPS = 5'h10;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_DSUB,
        OP_NEG,
        OP_TWOS_COMPLEMENT_DOUBLE,
        OP_DMUL,
        OP_DIV
    } nmd_op_type;

    typedef enum logic [1:0] {
        DS_OPERAND,
        DS_SHORT_POS,
        DS_SHORT_NEG
    } nmd_divsrc_type;

    typedef struct packed {
        nmd_op_type     op;
        nmd_divsrc_type dsrc;
        logic [7:0]     clocks;
        logic [1:0]     fetches;
        logic [1:0]     operands;
    } nmd_decode_type;

    typedef struct packed {
        logic [15:0] dividend;
        logic [15:0] divisor;
    } nmd_div_req_type;

    typedef struct packed {
        logic [15:0] quotient;
        logic [15:0] remainder;
    } nmd_div_res_type;

endpackage

// file: logic/nmd_divider.sv
`timescale 1ns/1ps
module nmd_divider (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     start,
    input  wire nmd_pkg::nmd_div_req_type req,
    output nmd_pkg::nmd_div_res_type      res,
    output logic                          done
);
    logic [15:0] num_q;
    logic [15:0] den_q;
    logic [15:0] quo_q;
    logic [16:0] rem_q;
    logic [4:0]  cnt_q;
    logic        qneg_q;
    logic        rneg_q;
    logic        done_q;
    logic [16:0] shifted;
    logic [16:0] trial;

    assign shifted = {rem_q[15:0], num_q[15]};
    assign trial   = shifted - {1'b0, den_q};

    // Restoring division on magnitudes, one bit a cycle
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            num_q  <= '0;
            den_q  <= '0;
            quo_q  <= '0;
            rem_q  <= '0;
            cnt_q  <= '0;
            qneg_q <= 1'b0;
            rneg_q <= 1'b0;
        end
        else if (start)
        begin
            num_q  <= req.dividend[15] ? 16'(-req.dividend) : req.dividend;
            den_q  <= req.divisor[15] ? 16'(-req.divisor) : req.divisor;
            quo_q  <= '0;
            rem_q  <= '0;
            cnt_q  <= nmd_pkg::DIV_STEPS;
            qneg_q <= req.dividend[15] ^ req.divisor[15];
            rneg_q <= req.dividend[15]; // RL17
        end
        else if (cnt_q != '0)
        begin
            num_q <= {num_q[14:0], 1'b0};
            quo_q <= {quo_q[14:0], ~trial[16]};
            rem_q <= trial[16] ? shifted : trial;
            cnt_q <= cnt_q - 5'd1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            done_q <= 1'b0;
        else
            done_q <= (cnt_q == 5'd1);
    end

    assign done          = done_q;
    assign res.quotient  = qneg_q ? 16'(-quo_q) : quo_q;
    assign res.remainder = rneg_q ? 16'(-rem_q[15:0]) : rem_q[15:0]; // RL17
endmodule

// file: logic/nmd_arith.sv
`timescale 1ns/1ps
// Functional notes
// RL1: Carry clear: status 0010 zero, 0001 negative, 0100 positive result.
// RL2: Carry set: status 1010, 1001, 1100; top bit is the carry.
// RL3: Single negate writes two's complement; status without carry bit.
// RL4: Negating zero gives zero and no overflow.
// RL5: Negating 8000 hex sets overflow bit 4 and exits; result unchanged.
// RL6: Single negate opcode B4, five clocks, one fetch, no operand cycle.
// RL7: Double negate writes 32-bit complement, high half in first register.
// RL8: Double negate of 80000000 overflows; opcode B5, 18 clocks, one fetch.
// RL9: Double multiply keeps low 32 product bits; status from the pair.
// RL10: Same signs: overflow if upper half nonzero or kept sign set.
// RL11: Opposite signs: overflow if upper half not all ones or sign clear.
// RL12: No multiply overflow when either operand is zero.
// RL13: Memory double multiply opcode C6, 132 clocks, two fetch, two operand.
// RL14: Register double multiply opcode C7, 126 clocks, one fetch.
// RL15: Divide: quotient in first, remainder in second; status from quotient.
// RL16: Divide overflows on zero divisor or 8000 divided by FFFF.
// RL17: Nonzero remainder takes the sign of the dividend.
// RL18: Short divides D3 and D2, field is N minus one, 98 clocks.
// RL19: Positive short divide uses opcode D2 with the N minus one field.
// RL20: Register divide D1 98 clocks; immediate 4A sub 6, 102 clocks.
// RL21: Memory divide takes 103 clocks, two fetch, one operand cycle.
// RL22: Timing triple order: clocks, fetch cycles, operand cycles.
// RL23: Subtract adds inverted operand plus one; sign-based overflow.
// RL24: Negative short divide uses minus N, positive uses N.
// RL25: Overflow exit leaves destination and status as documented here.
module nmd_arith (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             busy,
    output logic             fixed_overflow
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } nmd_state_type;

    nmd_state_type               state_q;
    logic [7:0]                  cnt_q;
    logic [31:0]                 dest_q;
    logic [31:0]                 operand_q;
    logic [15:0]                 instr_q;
    nmd_pkg::nmd_decode_type     dec_q;
    nmd_pkg::nmd_decode_type     dec_new;
    logic [3:0]                  cs_q;
    logic                        bad_q;
    logic                        ovf_pend_q;
    logic                        ap_valid_q;
    logic                        ap_write_q;
    logic [7:0]                  ap_addr_q;
    logic                        wr_en;
    logic                        idle;
    logic                        accept;
    logic                        finish;
    logic [32:0]                 diff;
    logic signed [63:0]          prod;
    logic [15:0]                 neg16;
    logic [31:0]                 neg32;
    logic [15:0]                 divisor;
    logic [31:0]                 res;
    logic [3:0]                  cs_new;
    logic                        ovf;
    logic                        wr_dest;
    logic                        upd_cs;
    logic                        same_sign;
    nmd_pkg::nmd_div_req_type    div_req;
    nmd_pkg::nmd_div_res_type    div_res;

    function automatic nmd_pkg::nmd_decode_type mk(
        input nmd_pkg::nmd_op_type     op,
        input nmd_pkg::nmd_divsrc_type ds,
        input logic [7:0]              clk,
        input logic [1:0]              fch,
        input logic [1:0]              opn
    );
        nmd_pkg::nmd_decode_type d;
        d.op       = op;
        d.dsrc     = ds;
        d.clocks   = clk;
        d.fetches  = fch;
        d.operands = opn;
        return d;
    endfunction

    function automatic nmd_pkg::nmd_decode_type decode(
        input logic [15:0] w
    );
        nmd_pkg::nmd_decode_type d;
        d = mk(nmd_pkg::OP_NONE, nmd_pkg::DS_OPERAND, '0,
               nmd_pkg::BUS_NONE, nmd_pkg::BUS_NONE);
        case (w[15:8])
            nmd_pkg::OPC_DSUB_MEM:
                d = mk(nmd_pkg::OP_DSUB, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_DSUB_MEM, nmd_pkg::BUS_TWO,
                       nmd_pkg::BUS_TWO);
            nmd_pkg::OPC_DSUB_REG:
                d = mk(nmd_pkg::OP_DSUB, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_DSUB_REG, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_NEG: // RL6
                d = mk(nmd_pkg::OP_NEG, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_NEG, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_TWOS_COMPLEMENT_DOUBLE: // RL8
                d = mk(nmd_pkg::OP_TWOS_COMPLEMENT_DOUBLE, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_TWOS_COMPLEMENT_DOUBLE, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_DMUL_MEM: // RL13
                d = mk(nmd_pkg::OP_DMUL, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_DMUL_MEM, nmd_pkg::BUS_TWO,
                       nmd_pkg::BUS_TWO);
            nmd_pkg::OPC_DMUL_REG: // RL14
                d = mk(nmd_pkg::OP_DMUL, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_DMUL_REG, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_DIV_MEM: // RL21
                d = mk(nmd_pkg::OP_DIV, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_DIV_MEM, nmd_pkg::BUS_TWO,
                       nmd_pkg::BUS_ONE);
            nmd_pkg::OPC_DIV_REG: // RL20
                d = mk(nmd_pkg::OP_DIV, nmd_pkg::DS_OPERAND,
                       nmd_pkg::CLK_DIV_REG, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_DIV_POS: // RL19
                d = mk(nmd_pkg::OP_DIV, nmd_pkg::DS_SHORT_POS,
                       nmd_pkg::CLK_DIV_SHRT, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_DIV_NEG: // RL18
                d = mk(nmd_pkg::OP_DIV, nmd_pkg::DS_SHORT_NEG,
                       nmd_pkg::CLK_DIV_SHRT, nmd_pkg::BUS_ONE,
                       nmd_pkg::BUS_NONE);
            nmd_pkg::OPC_IMM_GRP:
                if (w[3:0] == nmd_pkg::SUB_DIV_IMM) // RL20
                    d = mk(nmd_pkg::OP_DIV, nmd_pkg::DS_OPERAND,
                           nmd_pkg::CLK_DIV_IMM, nmd_pkg::BUS_TWO,
                           nmd_pkg::BUS_NONE);
            default: ;
        endcase
        return d;
    endfunction

    // Divisor: operand word, or N / minus N from the short field
    function automatic logic [15:0] pick_divisor(
        input nmd_pkg::nmd_divsrc_type ds,
        input logic [3:0]              field,
        input logic [15:0]             opnd
    );
        logic [15:0] n;
        n = {12'h000, field} + nmd_pkg::ONE_16; // RL18
        case (ds)
            nmd_pkg::DS_SHORT_POS: return n; // RL24
            nmd_pkg::DS_SHORT_NEG: return 16'(-n); // RL24
            default:               return opnd;
        endcase
    endfunction

    function automatic logic [3:0] cs_code(
        input logic zero,
        input logic neg,
        input logic carry
    );
        logic [3:0] c;
        c = zero ? nmd_pkg::CS_ZERO : (neg ? nmd_pkg::CS_NEG
                                           : nmd_pkg::CS_POS); // RL1
        if (carry)
            c = c | nmd_pkg::CS_CARRY; // RL2
        return c;
    endfunction

    // AHB-Lite address phase
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q  <= '0;
        end
        else if (hready)
        begin
            ap_valid_q <= hsel && htrans[1];
            ap_write_q <= hwrite;
            ap_addr_q  <= haddr[7:0];
        end
    end

    assign idle    = (state_q == ST_IDLE);
    assign wr_en   = ap_valid_q && ap_write_q;
    assign dec_new = decode(hwdata[15:0]);
    assign accept  = wr_en && (ap_addr_q == nmd_pkg::OFS_INSTR) && idle
                     && (dec_new.op != nmd_pkg::OP_NONE);
    assign finish  = (state_q == ST_RUN) && (cnt_q == nmd_pkg::CNT_LAST);

    // Sequencer holds the op for its full clock count
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (accept)
                    begin
                        state_q <= ST_RUN;
                        cnt_q   <= dec_new.clocks; // RL22
                    end
                ST_RUN:
                begin
                    cnt_q <= cnt_q - 8'd1;
                    if (finish)
                        state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            instr_q <= '0;
            dec_q   <= mk(nmd_pkg::OP_NONE, nmd_pkg::DS_OPERAND, '0,
                          nmd_pkg::BUS_NONE, nmd_pkg::BUS_NONE);
        end
        else if (accept)
        begin
            instr_q <= hwdata[15:0];
            dec_q   <= dec_new;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            bad_q <= 1'b0;
        else if (wr_en && (ap_addr_q == nmd_pkg::OFS_INSTR) && idle)
            bad_q <= (dec_new.op == nmd_pkg::OP_NONE);
    end

    assign div_req.dividend = dest_q[31:16];
    assign div_req.divisor  = pick_divisor(dec_new.dsrc, hwdata[3:0],
                                           operand_q[31:16]);

    nmd_divider u_div (
        .mclk  (mclk),
        .reset (reset),
        .start (accept && (dec_new.op == nmd_pkg::OP_DIV)),
        .req   (div_req),
        .res   (div_res), // RL17
        .done  ()
    );

    assign diff = {1'b0, dest_q} + {1'b0, ~operand_q} + 33'd1; // RL23
    assign prod = $signed(dest_q) * $signed(operand_q);
    assign neg16 = 16'(-operand_q[31:16]);
    assign neg32 = 32'(-operand_q);
    assign divisor = pick_divisor(dec_q.dsrc, instr_q[3:0],
                                  operand_q[31:16]);
    assign same_sign = (dest_q[31] == operand_q[31]);

    // Result, status and overflow of the op in flight
    always_comb
    begin
        res     = dest_q;
        cs_new  = cs_q;
        ovf     = 1'b0;
        wr_dest = 1'b0;
        upd_cs  = 1'b0;
        unique case (dec_q.op)
            nmd_pkg::OP_NONE: ;
            nmd_pkg::OP_DSUB:
            begin
                res     = diff[31:0];
                ovf     = !same_sign && (diff[31] == operand_q[31]); // RL23
                cs_new  = cs_code(res == '0, diff[31], diff[32]); // RL2
                wr_dest = 1'b1;
                upd_cs  = 1'b1;
            end
            nmd_pkg::OP_NEG:
            begin
                res     = {neg16, dest_q[15:0]}; // RL3
                ovf     = (operand_q[31:16] == nmd_pkg::MOST_NEG_16); // RL5
                cs_new  = cs_code(neg16 == '0, neg16[15], 1'b0); // RL3
                wr_dest = 1'b1; // RL4
                upd_cs  = !ovf; // RL25
            end
            nmd_pkg::OP_TWOS_COMPLEMENT_DOUBLE:
            begin
                res     = neg32; // RL7
                ovf     = (operand_q == nmd_pkg::MOST_NEG_32); // RL8
                cs_new  = cs_code(neg32 == '0, neg32[31], 1'b0);
                wr_dest = 1'b1;
                upd_cs  = !ovf; // RL25
            end
            nmd_pkg::OP_DMUL:
            begin
                res     = prod[31:0]; // RL9
                ovf     = (same_sign
                           ? ((prod[63:32] != '0) || prod[31]) // RL10
                           : ((prod[63:32] != nmd_pkg::ALL_ONES_32)
                              || !prod[31])) // RL11
                          && (dest_q != '0) && (operand_q != '0); // RL12
                cs_new  = cs_code(prod[31:0] == '0, prod[31], 1'b0); // RL9
                wr_dest = 1'b1;
                upd_cs  = 1'b1;
            end
            nmd_pkg::OP_DIV:
            begin
                ovf     = (divisor == '0)
                          || ((dest_q[31:16] == nmd_pkg::MOST_NEG_16)
                              && (divisor == nmd_pkg::ALL_ONES_16)); // RL16
                res     = {div_res.quotient, div_res.remainder}; // RL15
                cs_new  = cs_code(div_res.quotient == '0,
                                  div_res.quotient[15], 1'b0); // RL15
                wr_dest = !ovf; // RL25
                upd_cs  = !ovf; // RL25
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            dest_q <= '0;
        else if (finish && wr_dest)
            dest_q <= res;
        else if (wr_en && idle && (ap_addr_q == nmd_pkg::OFS_DEST))
            dest_q <= hwdata;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            operand_q <= '0;
        else if (wr_en && idle && (ap_addr_q == nmd_pkg::OFS_OPERAND))
            operand_q <= hwdata;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            cs_q <= nmd_pkg::CS_RESET;
        else if (finish && upd_cs)
            cs_q <= cs_new;
    end

    // Overflow flag: set beats a same-cycle clear
    always_ff @(posedge mclk)
    begin
        if (reset)
            ovf_pend_q <= 1'b0;
        else if (finish && ovf)
            ovf_pend_q <= 1'b1; // RL5
        else if (wr_en && (ap_addr_q == nmd_pkg::OFS_PEND)
                 && hwdata[nmd_pkg::PI_OVF_BIT])
            ovf_pend_q <= 1'b0;
    end

    // Read data
    always_comb
    begin
        hrdata = '0;
        if (ap_valid_q && !ap_write_q)
        begin
            case (ap_addr_q)
                nmd_pkg::OFS_INSTR:   hrdata[15:0] = instr_q;
                nmd_pkg::OFS_DEST:    hrdata = dest_q;
                nmd_pkg::OFS_OPERAND: hrdata = operand_q;
                nmd_pkg::OFS_STATUS:
                begin
                    hrdata[nmd_pkg::ST_BUSY_BIT]       = !idle;
                    hrdata[nmd_pkg::ST_CS_LSB +: 4]    = cs_q;
                    hrdata[nmd_pkg::ST_BAD_BIT]        = bad_q;
                end
                nmd_pkg::OFS_PEND:
                    hrdata[nmd_pkg::PI_OVF_BIT] = ovf_pend_q;
                nmd_pkg::OFS_TIMING: // RL22
                begin
                    hrdata[nmd_pkg::TM_CLK_LSB +: 8]   = dec_q.clocks;
                    hrdata[nmd_pkg::TM_FETCH_LSB +: 2] = dec_q.fetches;
                    hrdata[nmd_pkg::TM_OPND_LSB +: 2]  = dec_q.operands;
                end
                default: hrdata = '0;
            endcase
        end
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign busy           = !idle;
    assign fixed_overflow = ovf_pend_q;

endmodule

// file: testbench/nmd_arith_sva.sv
`timescale 1ns/1ps
module nmd_arith_sva (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        busy,
    input wire logic        fixed_overflow
);
    logic       wr_q;
    logic [7:0] ad_q;
    int         cnt_q;
    int         exp_q;
    wire        go  = wr_q && ad_q == 8'h00 && !busy;
    wire        clr = wr_q && ad_q == 8'h10 && hwdata[4];
    function automatic int clk_of(input logic [15:0] w);
        case (w[15:8])
            8'hb4: return 5;
            8'hb5, 8'hb7: return 18;
            8'hb6: return 24;
            8'hc6: return 132;
            8'hc7: return 126;
            8'hd1, 8'hd2, 8'hd3: return 98;
            8'hd0: return 103;
            8'h4a: return (w[3:0] == 4'h6) ? 102 : 0;
            default: return 0;
        endcase
    endfunction
    always_ff @(posedge mclk)
    begin
        wr_q  <= !reset && hsel && htrans[1] && hwrite && hreadyout;
        ad_q  <= haddr[7:0];
        cnt_q <= go ? 0 : cnt_q + int'(busy);
        exp_q <= go ? clk_of(hwdata[15:0]) : exp_q;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence neg_go;
        go && hwdata[15:8] == 8'hb4;
    endsequence
    sequence neg_run;
        busy [*5] ##1 !busy;
    endsequence
    a_neg_clocks: assert property (neg_go |=> neg_run)
        else $error("negate busy span wrong");
    a_twos_complement_double_span: assert property (go && hwdata[15:8] == 8'hb5
        |=> busy [*8])
        else $error("double negate ended early");
    a_busy_len: assert property ($fell(busy) |-> cnt_q == exp_q)
        else $error("busy span differs from clock count");
    a_busy_cause: assert property ($rose(busy) |-> $past(go))
        else $error("busy rose without an instruction");
    a_illegal_idle: assert property (go && clk_of(hwdata[15:0]) == 0
        |=> !busy)
        else $error("unknown opcode started");
    a_ovf_rise: assert property ($rose(fixed_overflow)
        |-> $past(busy) && !busy)
        else $error("overflow set outside completion");
    a_ovf_sticky: assert property (fixed_overflow && !clr
        |=> fixed_overflow)
        else $error("overflow flag lost");
    a_ovf_clear: assert property (clr && !busy |=> !fixed_overflow)
        else $error("overflow flag not cleared");
endmodule
bind nmd_arith nmd_arith_sva chk_u (.mclk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hreadyout, .busy, .fixed_overflow);

// file: testbench/nmd_host.sv
`timescale 1ns/1ps
module nmd_host (
    input  wire logic        mclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end
    // One single word transfer, waiting on hready at both phases
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge mclk); while (!hready);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (!hready);
        r = hrdata;
    endtask
endmodule

// file: testbench/tb_nmd_arith.sv
`timescale 1ns/1ps
module tb_nmd_arith;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp, busy, fixed_overflow;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    int          n_mismatch = 0;
    int          n_compared = 0;
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    nmd_arith dut_u (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .busy,
        .fixed_overflow);
    nmd_host host_u (.mclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata);
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        host_u.xfer(1'b0, a, 32'h0, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_u.xfer(1'b1, a, d, x);
    endtask
    task automatic tim(input logic [31:0] e);
        rd(8'h14);
        chk({7'h0, hresp, r}, {8'h0, e});
    endtask
    task automatic run(input logic [15:0] w, input logic [31:0] dst,
        input logic [31:0] opn, input logic [31:0] res,
        input logic [3:0] cs, input logic ovf);
        logic [31:0] d, s;
        wr(8'h08, opn);
        wr(8'h04, dst);
        wr(8'h00, {16'h0, w});
        @(posedge mclk);
        #1;
        for (int i = 0; i < 200 && busy; i++)
        begin
            @(posedge mclk);
            #1;
        end
        rd(8'h04);
        d = r;
        rd(8'h0c);
        s = r;
        rd(8'h10);
        chk({d, 2'h0, fixed_overflow, r[4], s[4:1]},
            {res, 2'h0, ovf, ovf, cs});
        wr(8'h10, 32'h10);
    endtask
    task automatic s_negate;
        rd(8'h0c);
        chk({8'h0, r}, 40'h0);
        run(16'hb400, 0, 32'h0005_0000, 32'hfffb_0000, 4'h1, 0);
        run(16'hb400, 0, 0, 0, 4'h2, 0);
        run(16'hb400, 0, 32'h8000_0000, 32'h8000_0000, 4'h2, 1);
        tim(32'h0105);
        run(16'hb500, 0, 32'h1, 32'hffff_ffff, 4'h1, 0);
        run(16'hb500, 0, 32'h8000_0000, 32'h8000_0000, 4'h1, 1);
        tim(32'h0112);
    endtask
    task automatic s_multiply;
        run(16'hc700, 32'h3, 32'hffff_fffe, 32'hffff_fffa, 4'h1, 0);
        run(16'hc700, 32'h1_0000, 32'h1_0000, 0, 4'h2, 1);
        run(16'hc700, 32'h1_0000, 32'hffff_0000, 0, 4'h2, 1);
        run(16'hc700, 0, 32'h8000_0000, 0, 4'h2, 0);
        tim(32'h017e);
        run(16'hc600, 32'h2, 32'h3, 32'h6, 4'h4, 0);
        tim(32'h0002_0284);
    endtask
    task automatic s_divide;
        run(16'hd100, 32'hfff9_0000, 32'h2_0000, 32'hfffd_ffff, 1, 0);
        tim(32'h0162);
        run(16'hd100, 32'h7_0000, 0, 32'h7_0000, 4'h1, 1);
        run(16'hd100, 32'h80000000, 32'hffff0000, 32'h80000000, 1, 1);
        run(16'hd203, 32'h64_0000, 0, 32'h19_0000, 4'h4, 0);
        run(16'hd303, 32'h64_0000, 0, 32'hffe7_0000, 4'h1, 0);
        run(16'hd30f, 32'h10_0000, 0, 32'hffff_0000, 4'h1, 0);
        run(16'h4a06, 32'h9_0000, 32'h2_0000, 32'h4_0001, 4'h4, 0);
        tim(32'h0266);
        run(16'hd000, 32'hfff7_0000, 32'h2_0000, 32'hfffc_ffff, 1, 0);
        tim(32'h0001_0267);
    endtask
    task automatic s_subtract;
        run(16'hb700, 32'h1, 32'h2, 32'hffff_ffff, 4'h1, 0);
        run(16'hb600, 32'h3, 32'h5, 32'hffff_fffe, 4'h1, 0);
        run(16'hb700, 32'h5, 32'h3, 32'h2, 4'hc, 0);
        run(16'hb700, 32'h3, 32'h3, 0, 4'ha, 0);
        run(16'hb700, 32'h8000_0000, 1, 32'h7fff_ffff, 4'hc, 1);
        wr(8'h00, 32'h0);
        rd(8'h0c);
        chk({38'h0, r[5], r[0]}, 40'h2);
        rd(8'h20);
        chk({8'h0, r}, 40'h0);
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        s_negate;
        s_multiply;
        s_divide;
        s_subtract;
        conclude;
    end
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        conclude;
    end
endmodule
